// File: verilog/rtc_defines.vh
// Purpose: Constants for the rotate-through-carry unit
// Assumes: 12-bit instruction word, 8-bit data, 5-bit file address
// Notes:   Definitions only
`ifndef RTC_DEFINES_VH
`define RTC_DEFINES_VH
`define RTC_OP_HI_POS      11
`define RTC_OP_HI_LO       8
`define RTC_OP_HI_VAL      4'h3
`define RTC_OP_SUB_HI      7
`define RTC_OP_SUB_LO      6
`define RTC_SUB_ROT_LEFT   2'h1
`define RTC_SUB_ROT_RIGHT  2'h0
`define RTC_DEST_POS       5
`define RTC_ADDR_HI        4
`define RTC_ADDR_LO        0
`define RTC_CARRY_POS      0
`define RTC_DEST_ACC       1'h0
`define RTC_DEST_FILE      1'h1
`define RTC_ACC_RESET      8'h00
`define RTC_STATUS_RESET   8'h00
`define RTC_WR_EN_RESET    1'h0
`define RTC_FILE_DATA_RESET 8'h00
`define RTC_FILE_ADDR_RESET 5'h00
`define RTC_DATA_MSB       7
`define RTC_DATA_LSB       0
`endif

// File: verilog/rtc_rotate_unit.v
// Purpose: Rotate-through-carry datapath slice of an 8-bit core
// Assumes: Register file read is combinational; write lands on the next clk edge
// Notes:   One instruction per cycle, no stalls
// Notes on behaviour
// - Left rotate: old carry into bit 0, old bit 7 into carry.
// - Right rotate: old carry into bit 7, old bit 0 into carry.
// - Carry is bit 0 of the status register.
// - Destination bit 0 writes accumulator, file register untouched.
// - Destination bit 1 writes file register, accumulator untouched.
`timescale 1ns/1ps
`include "rtc_defines.vh"
module rtc_rotate_unit (
    input  wire        clk,
    input  wire        rst,
    input  wire        instr_valid,
    input  wire [11:0] instr_word,
    input  wire [7:0]  file_rd_data,
    input  wire [7:0]  status_in,
    output wire [4:0]  file_addr,
    output wire        file_wr_en,
    output wire [7:0]  file_wr_data,
    output wire [4:0]  file_wr_addr,
    output wire        status_wr_en,
    output wire [7:0]  status_wr_data,
    output reg  [7:0]  acc_q,
    output wire        rotate_hit
);

    // Widths of the core's datapath, fixed
    localparam DATA_W  = 8;
    localparam ADDR_W  = 5;
    localparam INSTR_W = 12;

    // Decode of the current instruction
    wire                rotate_left_carry_op;
    wire                rotate_right_carry_op;
    wire                dest_file;
    wire                dest_acc;
    wire                file_store;
    wire                acc_load;
    wire                carry_old;

    // Both candidate results, built bit by bit
    wire [DATA_W-1:0]   rot_left_val;
    wire [DATA_W-1:0]   rot_right_val;
    wire                rot_left_carry;
    wire                rot_right_carry;
    wire [DATA_W-2:0]   status_keep;

    // Selected result and next values of the flops
    reg  [DATA_W-1:0]   rot_value;
    reg                 carry_new;
    reg                 file_wr_en_d;
    reg  [DATA_W-1:0]   file_wr_data_d;
    reg  [ADDR_W-1:0]   file_wr_addr_d;
    reg                 status_wr_en_d;
    reg  [DATA_W-1:0]   status_wr_data_d;
    reg  [DATA_W-1:0]   acc_d;

    // Flops behind the registered outputs
    reg                 file_wr_en_q;
    reg  [DATA_W-1:0]   file_wr_data_q;
    reg  [ADDR_W-1:0]   file_wr_addr_q;
    reg                 status_wr_en_q;
    reg  [DATA_W-1:0]   status_wr_data_q;

    genvar gi;

    // Opcode decode shared by both operations
    function is_rot;
        input [INSTR_W-1:0] w;
        input [1:0]         sub;
        begin
            is_rot = (w[`RTC_OP_HI_POS:`RTC_OP_HI_LO] == `RTC_OP_HI_VAL) &&
                     (w[`RTC_OP_SUB_HI:`RTC_OP_SUB_LO] == sub);
        end
    endfunction

    // Destination decode, used by the file write and the accumulator load
    function dest_is;
        input [INSTR_W-1:0] w;
        input               sel;
        begin
            dest_is = (w[`RTC_DEST_POS] == sel);
        end
    endfunction

    assign rotate_left_carry_op  = instr_valid && is_rot(instr_word, `RTC_SUB_ROT_LEFT);
    assign rotate_right_carry_op = instr_valid && is_rot(instr_word, `RTC_SUB_ROT_RIGHT);
    assign rotate_hit            = rotate_left_carry_op || rotate_right_carry_op;
    assign dest_file             = dest_is(instr_word, `RTC_DEST_FILE);
    assign dest_acc              = dest_is(instr_word, `RTC_DEST_ACC);
    assign file_store            = rotate_hit && dest_file;
    assign acc_load              = rotate_hit && dest_acc;
    assign file_addr             = instr_word[`RTC_ADDR_HI:`RTC_ADDR_LO];
    assign carry_old             = status_in[`RTC_CARRY_POS];

    // The bit leaving the register becomes the new carry
    assign rot_left_carry  = file_rd_data[`RTC_DATA_MSB];
    assign rot_right_carry = file_rd_data[`RTC_DATA_LSB];
    // Status bits above the carry pass through untouched
    assign status_keep     = status_in[`RTC_DATA_MSB:`RTC_CARRY_POS + 1];

    // Inner bits take a neighbour; the end bit on the entry side takes the old carry
    generate
        for (gi = 0; gi < DATA_W; gi = gi + 1) begin : g_rot_bit
            if (gi == 0) begin : g_lsb
                assign rot_left_val[gi]  = carry_old;
                assign rot_right_val[gi] = file_rd_data[gi + 1];
            end else if (gi == DATA_W - 1) begin : g_msb
                assign rot_left_val[gi]  = file_rd_data[gi - 1];
                assign rot_right_val[gi] = carry_old;
            end else begin : g_mid
                assign rot_left_val[gi]  = file_rd_data[gi - 1];
                assign rot_right_val[gi] = file_rd_data[gi + 1];
            end
        end
    endgenerate

    // Result select; with no rotate decoded the value is not used
    always @* begin
        rot_value = file_rd_data;
        if (rotate_left_carry_op) begin
            rot_value = rot_left_val;
        end else if (rotate_right_carry_op) begin
            rot_value = rot_right_val;
        end
    end

    always @* begin
        carry_new = carry_old;
        if (rotate_left_carry_op) begin
            carry_new = rot_left_carry;
        end else if (rotate_right_carry_op) begin
            carry_new = rot_right_carry;
        end
    end

    always @* begin
        file_wr_en_d = file_store;
    end

    always @* begin
        file_wr_data_d = rot_value;
    end

    always @* begin
        file_wr_addr_d = file_addr;
    end

    // Every rotate writes status, but only the carry bit changes
    always @* begin
        status_wr_en_d = rotate_hit;
    end

    always @* begin
        status_wr_data_d = {status_keep, carry_new};
    end

    // Accumulator keeps its value unless a rotate is aimed at it
    always @* begin
        acc_d = acc_q;
        if (acc_load) begin
            acc_d = rot_value;
        end
    end

    // All results commit at the single edge ending the instruction cycle
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            file_wr_en_q <= `RTC_WR_EN_RESET;
        end else begin
            file_wr_en_q <= file_wr_en_d;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            file_wr_data_q <= `RTC_FILE_DATA_RESET;
        end else begin
            file_wr_data_q <= file_wr_data_d;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            file_wr_addr_q <= `RTC_FILE_ADDR_RESET;
        end else begin
            file_wr_addr_q <= file_wr_addr_d;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            status_wr_en_q <= `RTC_WR_EN_RESET;
        end else begin
            status_wr_en_q <= status_wr_en_d;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            status_wr_data_q <= `RTC_STATUS_RESET;
        end else begin
            status_wr_data_q <= status_wr_data_d;
        end
    end

    // Working accumulator, seen by the rest of the core
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_q <= `RTC_ACC_RESET;
        end else begin
            acc_q <= acc_d;
        end
    end

    // Registered outputs
    assign file_wr_en     = file_wr_en_q;
    assign file_wr_data   = file_wr_data_q;
    assign file_wr_addr   = file_wr_addr_q;
    assign status_wr_en   = status_wr_en_q;
    assign status_wr_data = status_wr_data_q;

endmodule // rtc_rotate_unit

// File: test/rtc_rotate_chk.sv
// Purpose: Port assertions for the rotate unit
// Assumes: One clock, async high reset
// Notes:   Bound below
`timescale 1ns/1ps
module rtc_rotate_chk (
    input wire        clk,
    input wire        rst,
    input wire        instr_valid,
    input wire [11:0] instr_word,
    input wire [7:0]  file_rd_data,
    input wire [7:0]  status_in,
    input wire [4:0]  file_addr,
    input wire        file_wr_en,
    input wire [7:0]  file_wr_data,
    input wire [4:0]  file_wr_addr,
    input wire        status_wr_en,
    input wire [7:0]  status_wr_data,
    input wire [7:0]  acc_q,
    input wire        rotate_hit
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_left_rot: assert property (rotate_hit && instr_word[6] |=>
        file_wr_data == {$past(file_rd_data[6:0]), $past(status_in[0])}) else $error("left");
    chk_right_rot: assert property (rotate_hit && !instr_word[6] |=>
        file_wr_data == {$past(status_in[0]), $past(file_rd_data[7:1])}) else $error("right");
    chk_carry_out: assert property (rotate_hit |=> status_wr_en &&
        status_wr_data == {$past(status_in[7:1]),
                           ($past(instr_word[6]) ? $past(file_rd_data[7]) : $past(file_rd_data[0]))})
        else $error("carry");
    chk_acc_dest: assert property (rotate_hit && !instr_word[5] |=> !file_wr_en &&
        acc_q == ($past(instr_word[6]) ? {$past(file_rd_data[6:0]), $past(status_in[0])}
                                       : {$past(status_in[0]), $past(file_rd_data[7:1])}))
        else $error("acc");
    chk_file_dest: assert property (rotate_hit && instr_word[5] |=>
        file_wr_en && file_wr_addr == $past(file_addr) && $stable(acc_q)) else $error("file");
    chk_no_rotate: assert property (!rotate_hit |=>
        !file_wr_en && !status_wr_en && $stable(acc_q)) else $error("idle");
    chk_hit_decode: assert property (
        rotate_hit == (instr_valid && instr_word[11:8] == 4'h3 && !instr_word[7]) &&
        file_addr == instr_word[4:0]) else $error("decode");
endmodule // rtc_rotate_chk
bind rtc_rotate_unit rtc_rotate_chk rtc_rotate_chk_i (.*);

// File: test/tb_rtc_rotate_unit.sv
// Purpose: Random self-checking bench for the rotate unit
// Assumes: Inputs driven at falling edge
// Notes:   Two fixed cases lead the random run
`timescale 1ns/1ps
module tb_rtc_rotate_unit;
    localparam N_INSTR  = 400;
    localparam MID_RST  = 200;
    // One cycle per instruction plus reset, with a fourfold margin
    localparam LIMIT_NS = (N_INSTR + 50) * 8 * 4;

    reg        clk             = 1'h0;
    reg        rst             = 1'h1;
    reg        v               = 1'h0;
    reg        h;
    reg [11:0] w               = 12'h000;
    reg [7:0]  fd              = 8'h00;
    reg [7:0]  st              = 8'h00;
    reg [7:0]  ea              = 8'h00;
    reg [8:0]  r;
    wire [4:0] fa;
    wire [4:0] wa;
    wire       we;
    wire       se;
    wire       hit;
    wire [7:0] wd;
    wire [7:0] sd;
    wire [7:0] acc;
    integer    n_errors        = 0;
    integer    samples_checked = 0;
    integer    i;

    rtc_rotate_unit rtc_rotate_unit_i (
        .clk            (clk),
        .rst            (rst),
        .instr_valid    (v),
        .instr_word     (w),
        .file_rd_data   (fd),
        .status_in      (st),
        .file_addr      (fa),
        .file_wr_en     (we),
        .file_wr_data   (wd),
        .file_wr_addr   (wa),
        .status_wr_en   (se),
        .status_wr_data (sd),
        .acc_q          (acc),
        .rotate_hit     (hit)
    );

    always #4 clk = ~clk;

    // Rotate through carry: new carry in bit 8, rotated byte below it
    function [8:0] exp_rot;
        input [7:0] data;
        input       carry;
        input       left;
        begin
            if (left) begin
                exp_rot = {data, carry};
            end else begin
                exp_rot = {data[0], carry, data[7:1]};
            end
        end
    endfunction

    // A valid word is a rotate when its top five bits are 0011 then 0
    function exp_hit;
        input        valid;
        input [11:0] word;
        begin
            exp_hit = valid && (word[11:8] == 4'h3) && (word[7] == 1'h0);
        end
    endfunction

    task check;
        input [31:0] seen;
        input [31:0] exp;
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task results;
        begin
            $display("checked %0d errors %0d", samples_checked, n_errors);
            if (n_errors == 0 && samples_checked > 0) begin
                $display("[ PASS ]");
            end else begin
                $display("[ FAIL ]");
            end
            $finish;
        end
    endtask

    // Reset in mid-run: every registered output must clear while it is held
    task mid_reset;
        begin
            v   = 1'h0;
            rst = 1'h1;
            @(negedge clk);
            check(we, 1'h0);
            check(se, 1'h0);
            check(wd, 8'h00);
            check(wa, 5'h00);
            check(sd, 8'h00);
            check(acc, 8'h00);
            ea = 8'h00;
            @(negedge clk);
            rst = 1'h0;
        end
    endtask

    initial begin
        #LIMIT_NS;
        n_errors = n_errors + 1;
        results;
    end

    initial begin
        i = $urandom(32'hbbca96f1);
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst = 1'h0;
        for (i = 0; i < N_INSTR; i = i + 1) begin
            if (i == MID_RST) begin
                mid_reset;
            end
            v  = (i < 2) || ($urandom % 8 != 0);
            fd = (i < 2) ? 8'he6 : 8'($urandom);
            st = (i < 2) ? 8'h00 : 8'($urandom);
            w  = (i == 0) ? 12'h345 : (i == 1) ? 12'h325 : {5'h06, 7'($urandom)};
            if (i >= 2 && $urandom % 8 == 0) begin
                w[11:7] = 5'($urandom);
            end
            h = exp_hit(v, w);
            r = exp_rot(fd, st[0], w[6]);
            #1;
            check(hit, h);
            check(fa, w[4:0]);
            @(negedge clk);
            check(se, h);
            check(we, h && w[5]);
            if (h) begin
                check({wd, sd}, {r[7:0], st[7:1], r[8]});
            end
            if (h && w[5]) begin
                check(wa, w[4:0]);
            end
            if (h && !w[5]) begin
                ea = r[7:0];
            end
            check(acc, ea);
        end
        results;
    end
endmodule // tb_rtc_rotate_unit
